// ---- common/obcal_pkg.sv ----
package obcal_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_FILTER = 12'h004;
    localparam logic [11:0] OFF_TARGET = 12'h008;
    localparam logic [11:0] OFF_LIMITS = 12'h00c;
    localparam logic [11:0] OFF_GAIN = 12'h010;
    localparam logic [11:0] OFF_FINE = 12'h014;
    localparam logic [11:0] OFF_COARSE = 12'h018;
    localparam logic [11:0] OFF_STATUS = 12'h01c;
    // Control register bit positions.
    localparam int CTRL_SWRST = 0;
    localparam int CTRL_PDN = 1;
    localparam int CTRL_DIRECT = 2;
    localparam int CTRL_SOF = 3;
    localparam int CTRL_FRAME = 4;
    // Filter register: weight shift in [3:0], pixel count exponent in [6:4].
    localparam int FLT_WSH_LSB = 0;
    localparam int FLT_NPIX_LSB = 4;
    localparam logic [3:0] WSH_MAX = 4'h8;
    localparam logic [2:0] NPIX_MAX = 3'h6;
    // Limits register: cold limit [9:0], hot limit [25:16].
    localparam int LIM_HOT_LSB = 16;
    // Reset values.
    localparam logic [9:0] TARGET_RST = 10'h040;
    localparam logic [9:0] HOT_RST = 10'h3ff;
    localparam logic [9:0] COLD_RST = 10'h000;
    localparam logic [3:0] WSH_RST = 4'h0;
    localparam logic [2:0] NPIX_RST = 3'h0;
    localparam logic [9:0] GAIN_RST = 10'h000;
    localparam logic [8:0] FINE_RST = 9'h000;
    localparam logic [7:0] COARSE_RST = 8'h00;
    localparam logic signed [10:0] FINE_RANGE = 11'sh0ff;
    // Gain code thresholds for the coarse step multiplier.
    localparam logic [9:0] GAIN_T1 = 10'h080;
    localparam logic [9:0] GAIN_T2 = 10'h0c0;
    localparam logic [9:0] GAIN_T3 = 10'h100;

    typedef struct packed {
        logic swrst;
        logic pdn;
        logic direct;
        logic sof;
        logic frame_start;
    } obcal_ctrl_t;

    typedef enum logic [1:0] {ST_IDLE, ST_ACC, ST_UPD} obcal_state_t;
endpackage

// ---- hw/obcal_top.sv ----
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Reset pin restores every register default.
// - Power-on reset needs the reset pin held low at power.
// - Software reset bit resets the device.
// - Standby pin low holds low-power state.
// - Power-down bit also forces standby.
// - Registers stay writable during standby.
// - Strobe falling starts a calibration cycle.
// - Average black, compare target, trim fine.
// - Beyond 255 codes use coarse and fine.
// - Coarse steps one unit opposite offset sign.
// - Coarse step equals n fine codes, n from 4 down to 1 as gain rises.
// - Weighted rolling average, weight down to 1/256.
// - Out-of-limit pixel after a line's first replaced by previous pixel.
// - Frame-start mode: no limits, weight one.
// - Black pixels per line are one to 64, a power of two.
// - Auto resumes from current DAC contents.
module obcal_top (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // CCD timing and converter data.
    input wire logic black_clamp_strobe_n,
    input wire logic conversion_clock,
    input wire logic [9:0] adc_data,
    input wire logic low_power_request_n,
    // Analog controls.
    output logic standby,
    output logic [8:0] fine_offset_dac,
    output logic [7:0] coarse_offset_dac
);

    logic soft_rst_r;
    obcal_pkg::obcal_ctrl_t ctrl_r;
    logic [3:0] wsh_r;
    logic [2:0] npix_r;
    logic [9:0] target_r;
    logic [9:0] hot_r;
    logic [9:0] cold_r;
    logic [9:0] gain_r;
    logic [8:0] fine_r;
    logic [7:0] coarse_r;
    logic [19:0] avg_r;
    logic [15:0] sum_r;
    logic [6:0] cnt_r;
    logic [9:0] prev_r;
    logic strobe_d_r;
    logic clk_d_r;
    logic first_line_r;
    logic quick_r;
    logic busy_r;
    obcal_pkg::obcal_state_t state_r;

    // Internal reset joins the pin with the one-cycle software reset pulse.
    // Power-on is covered by the pin, which a supervisor holds low at power.
    logic int_rst_n;
    assign int_rst_n = rst_n & ~soft_rst_r;

    logic wr;
    logic rd;
    assign wr = psel & penable & pwrite & pready;
    assign rd = psel & ~penable & ~pwrite;

    function automatic logic [2:0] coarse_mult(input logic [9:0] g);
        if (g < obcal_pkg::GAIN_T1) coarse_mult = 3'h4;
        else if (g < obcal_pkg::GAIN_T2) coarse_mult = 3'h3;
        else if (g < obcal_pkg::GAIN_T3) coarse_mult = 3'h2;
        else coarse_mult = 3'h1;
    endfunction

    // The residue saturates rather than wrapping while the coarse DAC
    // walks one step per line toward the target.
    function automatic logic [8:0] fine_clamp(input logic signed [11:0] v);
        if (v > obcal_pkg::FINE_RANGE)
            fine_clamp = 9'(obcal_pkg::FINE_RANGE);
        else if (v < -obcal_pkg::FINE_RANGE)
            fine_clamp = 9'(-obcal_pkg::FINE_RANGE);
        else
            fine_clamp = 9'(v);
    endfunction

    // Software reset is itself cleared by the pin only, so it lasts a cycle.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= wr && paddr == obcal_pkg::OFF_CTRL
                && pwdata[obcal_pkg::CTRL_SWRST];
        end
    end

    // Configuration registers; writes never look at standby.
    always_ff @(posedge clock or negedge int_rst_n) begin
        if (!int_rst_n) begin
            ctrl_r <= '0;
            wsh_r <= obcal_pkg::WSH_RST;
            npix_r <= obcal_pkg::NPIX_RST;
            target_r <= obcal_pkg::TARGET_RST;
            hot_r <= obcal_pkg::HOT_RST;
            cold_r <= obcal_pkg::COLD_RST;
            gain_r <= obcal_pkg::GAIN_RST;
        end else if (wr) begin
            case (paddr)
                obcal_pkg::OFF_CTRL: begin
                    ctrl_r.pdn <= pwdata[obcal_pkg::CTRL_PDN];
                    ctrl_r.direct <= pwdata[obcal_pkg::CTRL_DIRECT];
                    ctrl_r.sof <= pwdata[obcal_pkg::CTRL_SOF];
                    ctrl_r.frame_start <= pwdata[obcal_pkg::CTRL_FRAME];
                end
                obcal_pkg::OFF_FILTER: begin
                    wsh_r <= (pwdata[3:0] > obcal_pkg::WSH_MAX)
                        ? obcal_pkg::WSH_MAX : pwdata[3:0];
                    npix_r <= (pwdata[6:4] > obcal_pkg::NPIX_MAX)
                        ? obcal_pkg::NPIX_MAX : pwdata[6:4];
                end
                obcal_pkg::OFF_TARGET: target_r <= pwdata[9:0];
                obcal_pkg::OFF_LIMITS: begin
                    cold_r <= pwdata[9:0];
                    hot_r <= pwdata[25:16];
                end
                obcal_pkg::OFF_GAIN: gain_r <= pwdata[9:0];
                default: begin
                end
            endcase
        end else if (ctrl_r.frame_start && quick_r) begin
            ctrl_r.frame_start <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge int_rst_n) begin
        if (!int_rst_n) begin
            standby <= 1'b0;
        end else begin
            standby <= ~low_power_request_n | ctrl_r.pdn;
        end
    end

    // Edge detection on the strobe and conversion clock.
    always_ff @(posedge clock or negedge int_rst_n) begin
        if (!int_rst_n) begin
            strobe_d_r <= 1'b1;
            clk_d_r <= 1'b0;
        end else begin
            strobe_d_r <= black_clamp_strobe_n;
            clk_d_r <= conversion_clock;
        end
    end

    logic strobe_fall;
    logic sample_en;
    assign strobe_fall = strobe_d_r & ~black_clamp_strobe_n;
    assign sample_en = conversion_clock & ~clk_d_r;

    // Pixel conditioning: a defective pixel after a line's first repeats the previous pixel's value.
    logic [9:0] pix;
    logic in_lim;
    assign in_lim = adc_data <= hot_r && adc_data >= cold_r;
    assign pix = (in_lim || quick_r || cnt_r == 7'h00)
        ? adc_data : prev_r;

    logic [6:0] npix_total;
    assign npix_total = 7'(7'h01 << npix_r);

    // Rolling filter: avg holds the black level with 10 fraction bits.
    logic [9:0] line_avg;
    logic [19:0] line_fx;
    logic [3:0] wsh_eff;
    logic signed [21:0] avg_diff;
    logic [19:0] avg_new;
    assign line_avg = 10'(sum_r >> npix_r);
    assign line_fx = {line_avg, 10'h000};
    assign wsh_eff = quick_r ? 4'h0 : wsh_r;
    assign avg_diff = $signed({2'b00, line_fx}) - $signed({2'b00, avg_r});
    assign avg_new = 20'($signed({2'b00, avg_r}) + (avg_diff >>> wsh_eff));

    // Error of the filtered black level against the target.
    logic signed [11:0] err;
    logic signed [11:0] fine_next;
    logic signed [8:0] fine_s;
    assign fine_s = $signed(fine_r);
    assign err = $signed({2'b00, avg_new[19:10]}) - $signed({2'b00, target_r});
    assign fine_next = 12'(fine_s) - err;

    always_ff @(posedge clock or negedge int_rst_n) begin
        if (!int_rst_n) begin
            state_r <= obcal_pkg::ST_IDLE;
            sum_r <= '0;
            cnt_r <= '0;
            prev_r <= '0;
            avg_r <= {obcal_pkg::TARGET_RST, 10'h000};
            first_line_r <= 1'b1;
            quick_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            case (state_r)
                obcal_pkg::ST_IDLE: begin
                    busy_r <= 1'b0;
                    if (strobe_fall && !ctrl_r.direct && !standby) begin
                        state_r <= obcal_pkg::ST_ACC;
                        sum_r <= '0;
                        cnt_r <= '0;
                        busy_r <= 1'b1;
                        quick_r <= ctrl_r.sof
                            && (first_line_r || ctrl_r.frame_start);
                        first_line_r <= 1'b0;
                    end
                end
                obcal_pkg::ST_ACC: begin
                    if (sample_en) begin
                        sum_r <= sum_r + 16'(pix);
                        prev_r <= pix;
                        cnt_r <= cnt_r + 7'h01;
                        if (cnt_r + 7'h01 == npix_total) begin
                            state_r <= obcal_pkg::ST_UPD;
                        end
                    end
                end
                obcal_pkg::ST_UPD: begin
                    avg_r <= quick_r ? line_fx : avg_new;
                    quick_r <= 1'b0;
                    state_r <= obcal_pkg::ST_IDLE;
                end
                default: state_r <= obcal_pkg::ST_IDLE;
            endcase
        end
    end

    // DAC registers: host writes in any mode, the loop when not in direct mode.
    // Leaving direct mode keeps both values as the loop's start.
    always_ff @(posedge clock or negedge int_rst_n) begin
        if (!int_rst_n) begin
            fine_r <= obcal_pkg::FINE_RST;
            coarse_r <= obcal_pkg::COARSE_RST;
        end else if (wr && paddr == obcal_pkg::OFF_FINE) begin
            fine_r <= pwdata[8:0];
        end else if (wr && paddr == obcal_pkg::OFF_COARSE) begin
            coarse_r <= pwdata[7:0];
        end else if (state_r == obcal_pkg::ST_UPD && !ctrl_r.direct) begin
            if (fine_next > obcal_pkg::FINE_RANGE) begin
                coarse_r <= coarse_r + 8'h01;
                fine_r <= fine_clamp(fine_next
                    - $signed(12'(coarse_mult(gain_r))));
            end else if (fine_next < -obcal_pkg::FINE_RANGE) begin
                coarse_r <= coarse_r - 8'h01;
                fine_r <= fine_clamp(fine_next
                    + $signed(12'(coarse_mult(gain_r))));
            end else begin
                fine_r <= 9'(fine_next);
            end
        end
    end

    always_ff @(posedge clock or negedge int_rst_n) begin
        if (!int_rst_n) begin
            fine_offset_dac <= obcal_pkg::FINE_RST;
            coarse_offset_dac <= obcal_pkg::COARSE_RST;
        end else begin
            fine_offset_dac <= fine_r;
            coarse_offset_dac <= coarse_r;
        end
    end

    // APB slave: zero wait states, read data registered in the setup cycle.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            if (rd) begin
                case (paddr)
                    obcal_pkg::OFF_CTRL: prdata <= {27'h0, ctrl_r.frame_start,
                        ctrl_r.sof, ctrl_r.direct, ctrl_r.pdn, 1'b0};
                    obcal_pkg::OFF_FILTER: prdata <= {25'h0, npix_r, wsh_r};
                    obcal_pkg::OFF_TARGET: prdata <= {22'h0, target_r};
                    obcal_pkg::OFF_LIMITS: prdata <= {6'h0, hot_r, 6'h0, cold_r};
                    obcal_pkg::OFF_GAIN: prdata <= {22'h0, gain_r};
                    obcal_pkg::OFF_FINE: prdata <= {23'h0, fine_r};
                    obcal_pkg::OFF_COARSE: prdata <= {24'h0, coarse_r};
                    obcal_pkg::OFF_STATUS: prdata <= {20'h0, avg_r[19:10],
                        standby, busy_r};
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end

endmodule // obcal_top
`default_nettype wire

// ---- verification/obcal_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module obcal_monitor (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Converter side.
    input wire logic low_power_request_n,
    input wire logic standby,
    input wire logic [8:0] fine_offset_dac,
    input wire logic [7:0] coarse_offset_dac
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [2:0] quiet_r;
    // Host writes may move the DACs at will, so the step check waits
    // until the bus has been quiet for a while.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            quiet_r <= 3'h0;
        else if (psel && pwrite)
            quiet_r <= 3'h0;
        else if (quiet_r != 3'h7)
            quiet_r <= quiet_r + 3'h1;
    end
    sequence ctrl_wr_s;
        psel && penable && pready && pwrite && paddr == obcal_pkg::OFF_CTRL;
    endsequence
    AST_SETUP_ANSWER:
        assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    AST_READY_IN_ACCESS:
        assert property (pready |-> psel && penable)
        else $error("ready outside access");
    AST_NO_ERROR:
        assert property (!pslverr) else $error("error response");
    AST_RESET_DACS:
        assert property ($rose(rst_n) |-> fine_offset_dac == 9'h000
            && coarse_offset_dac == 8'h00 && !standby)
        else $error("outputs not cleared by reset");
    AST_STANDBY_PIN:
        assert property (!low_power_request_n [*3] |-> standby)
        else $error("standby pin ignored");
    AST_POWER_DOWN_BIT:
        assert property (ctrl_wr_s ##0 pwdata[obcal_pkg::CTRL_PDN]
            |-> ##[1:3] standby)
        else $error("power down bit ignored");
    AST_SOFT_RESET:
        assert property (ctrl_wr_s ##0 pwdata[obcal_pkg::CTRL_SWRST]
            |-> ##[1:4] (fine_offset_dac == 9'h000
            && coarse_offset_dac == 8'h00))
        else $error("software reset ignored");
    AST_COARSE_STEP:
        assert property (quiet_r >= 3'h3 && $changed(coarse_offset_dac)
            |-> 8'(coarse_offset_dac - $past(coarse_offset_dac))
            inside {8'h01, 8'hff})
        else $error("coarse moved by more than one");
endmodule // obcal_monitor
bind obcal_top obcal_monitor u_monitor (.clock, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .low_power_request_n,
    .standby, .fine_offset_dac, .coarse_offset_dac);
`default_nettype wire

// ---- verification/obcal_ccd_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module obcal_ccd_model (
    // Clock and line request.
    input wire logic clock,
    input wire logic start,
    input wire logic [39:0] pix,
    input wire logic [6:0] npix,
    // CCD timing and converter data.
    output logic black_clamp_strobe_n,
    output logic conversion_clock,
    output logic [9:0] adc_data,
    output logic busy
);
    initial begin
        black_clamp_strobe_n = 1'b1;
        conversion_clock = 1'b0;
        adc_data = 10'h000;
        busy = 1'b0;
    end
    // The conversion clock stands still between lines, and stale data
    // is inverted so that a late sample cannot pass for a good one.
    always @(posedge clock) begin
        if (start && !busy) begin
            busy <= 1'b1;
            black_clamp_strobe_n <= 1'b0;
            repeat (2) @(posedge clock);
            for (int i = 0; i < npix; i++) begin
                adc_data <= pix[(i % 4) * 10 +: 10];
                conversion_clock <= 1'b1;
                repeat (2) @(posedge clock);
                conversion_clock <= 1'b0;
                adc_data <= ~pix[(i % 4) * 10 +: 10];
                black_clamp_strobe_n <= 1'b1;
                @(posedge clock);
            end
            busy <= 1'b0;
        end else begin
            adc_data <= ~adc_data;
        end
    end
endmodule // obcal_ccd_model
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr, standby;
    logic low_power_request_n, black_clamp_strobe_n, conversion_clock;
    logic busy, start;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0] adc_data;
    logic [8:0] fine_offset_dac;
    logic [7:0] coarse_offset_dac;
    logic [39:0] pix;
    logic [6:0] npix;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    obcal_top u_dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .black_clamp_strobe_n,
        .conversion_clock, .adc_data, .low_power_request_n, .standby,
        .fine_offset_dac, .coarse_offset_dac);
    obcal_ccd_model u_ccd (.clock, .start, .pix, .npix, .busy,
        .black_clamp_strobe_n, .conversion_clock, .adc_data);
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic stop_test;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic dacs(input logic [8:0] f, input logic [7:0] c);
        chk({23'h0, fine_offset_dac}, {23'h0, f});
        chk({24'h0, coarse_offset_dac}, {24'h0, c});
    endtask
    // The first pixel of a line sits in bits 9:0.
    task automatic line(input logic [39:0] p, input logic [6:0] n);
        pix <= p;
        npix <= n;
        start <= 1'b1;
        do @(posedge clock); while (busy !== 1'b1);
        start <= 1'b0;
        do @(posedge clock); while (busy !== 1'b0);
        repeat (4) @(posedge clock);
    endtask
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, start} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pix = 40'h0;
        npix = 7'h0;
        low_power_request_n = 1'b1;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        rd_chk(obcal_pkg::OFF_TARGET, 32'h40);
        rd_chk(obcal_pkg::OFF_LIMITS, 32'h03ff0000);
        rd_chk(12'h020, 32'h0);
        wr(obcal_pkg::OFF_CTRL, 32'h4);
        wr(obcal_pkg::OFF_FINE, 32'h10);
        wr(obcal_pkg::OFF_COARSE, 32'h3);
        repeat (2) @(posedge clock);
        dacs(9'h010, 8'h03);
        low_power_request_n <= 1'b0;
        wr(obcal_pkg::OFF_TARGET, 32'h50);
        rd_chk(obcal_pkg::OFF_TARGET, 32'h50);
        chk({31'h0, standby}, 32'h1);
        low_power_request_n <= 1'b1;
        wr(obcal_pkg::OFF_CTRL, 32'h6);
        repeat (3) @(posedge clock);
        chk({31'h0, standby}, 32'h1);
        wr(obcal_pkg::OFF_CTRL, 32'h0);
        line({4{10'h050}}, 7'd1);
        dacs(9'h010, 8'h03);
        chk({31'h0, standby}, 32'h0);
        wr(obcal_pkg::OFF_FILTER, 32'h20);
        line({10'h060, 10'h064, 10'h060, 10'h05c}, 7'd4);
        dacs(9'h000, 8'h03);
        wr(obcal_pkg::OFF_LIMITS, 32'h00700010);
        line({10'h060, 10'h3ff, 10'h060, 10'h060}, 7'd4);
        dacs(9'h1f0, 8'h03);
        rd_chk(obcal_pkg::OFF_STATUS, 32'h180);
        wr(obcal_pkg::OFF_FILTER, 32'h21);
        line({4{10'h068}}, 7'd4);
        rd_chk(obcal_pkg::OFF_STATUS, 32'h190);
        wr(obcal_pkg::OFF_LIMITS, 32'h03ff0000);
        wr(obcal_pkg::OFF_FILTER, 32'h20);
        line({4{10'h3ff}}, 7'd4);
        dacs(9'h101, 8'h02);
        wr(obcal_pkg::OFF_LIMITS, 32'h00700010);
        wr(obcal_pkg::OFF_FILTER, 32'h28);
        wr(obcal_pkg::OFF_CTRL, 32'h18);
        line({10'h200, 10'h200, 10'h200, 10'h050}, 7'd4);
        rd_chk(obcal_pkg::OFF_STATUS, 32'h650);
        dacs(9'h101, 8'h01);
        wr(obcal_pkg::OFF_GAIN, 32'hfffffd00);
        rd_chk(obcal_pkg::OFF_GAIN, 32'h100);
        wr(obcal_pkg::OFF_CTRL, 32'h4);
        wr(obcal_pkg::OFF_FINE, 32'h0fe);
        wr(obcal_pkg::OFF_CTRL, 32'h0);
        wr(obcal_pkg::OFF_FILTER, 32'h20);
        line({4{10'h04e}}, 7'd4);
        dacs(9'h0ff, 8'h02);
        wr(obcal_pkg::OFF_CTRL, 32'h1);
        repeat (4) @(posedge clock);
        rd_chk(obcal_pkg::OFF_TARGET, 32'h40);
        dacs(9'h000, 8'h00);
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
